// [design/csrd_defines.svh]
// Opcodes, escape nibble, execution counts, flag positions and reset values
// Functional notes
// - Two-operand object code carries the source byte before the destination byte.
// - Opcode 04, source then destination register; sum lands in the destination.
// - Register field reaches 0 to 255; escape nibble selects working register 0 to 15.
// - D8 loads extended destination from stack, then stack pointer plus one; flags kept.
// - Push decrements stack pointer, then stores; 70 register, 71 indirect, 1F 70 immediate.
// - C8 pushes an extended-address source; flags kept; 3 fetch, 2 execute.
// - AF reloads program counter from two stack bytes, stack pointer plus two.
// - Rotate left carry: old carry into bit 0, old bit 7 into carry; 10, 11.
// - Rotate right carry: old carry into bit 7, old bit 0 into carry; C0, C1.
// - Plain rotates circulate the byte, wrapped bit copied to carry; E0/E1, 90/91.
// - Rotates update carry, zero, sign, overflow; decimal-adjust and half-carry kept.
`ifndef CSRD_DEFINES_SVH
`define CSRD_DEFINES_SVH

`define CSRD_OPC_ADD_REGS 8'h04
`define CSRD_OPC_POP_EXT 8'hd8
`define CSRD_OPC_PUSH_R 8'h70
`define CSRD_OPC_PUSH_IND 8'h71
`define CSRD_OPC_PREFIX 8'h1f
`define CSRD_OPC_PUSH_EXT 8'hc8
`define CSRD_OPC_RETURN 8'haf
`define CSRD_OPC_ROTL_CARRY_REG 8'h10
`define CSRD_OPC_ROTL_CARRY_IND 8'h11
`define CSRD_OPC_ROTR_CARRY_REG 8'hc0
`define CSRD_OPC_ROTR_CARRY_IND 8'hc1
`define CSRD_OPC_ROTL_REG 8'h90
`define CSRD_OPC_ROTL_IND 8'h91
`define CSRD_OPC_ROTR_REG 8'he0
`define CSRD_OPC_ROTR_IND 8'he1

// Escape nibble marking a working-register field
`define CSRD_ESC_NIBBLE 4'he

// Execution cycle counts
`define CSRD_EXEC_TWO 3'h2
`define CSRD_EXEC_THREE 3'h3
`define CSRD_EXEC_FOUR 3'h4
`define CSRD_EXEC_ADD 3'h3

// Flag bit positions
`define CSRD_FLAG_C 7
`define CSRD_FLAG_Z 6
`define CSRD_FLAG_S 5
`define CSRD_FLAG_V 4
`define CSRD_FLAG_D 3
`define CSRD_FLAG_H 2

// Reset values
`define CSRD_SP_RESET 12'h000
`define CSRD_PC_RESET 16'h0000
`define CSRD_FLAGS_RESET 8'h00

`endif

// [design/csrd_pkg.sv]
// Types shared by the stack and rotate decoder
package csrd_pkg;
  typedef enum logic [1:0] {
    CSRD_FETCH = 2'b01,
    CSRD_EXEC = 2'b10
  } csrd_state_t;
endpackage

// [design/csrd_core.sv]
// Stack, return, add and rotate decode and execute core
`timescale 1ns/100ps
`default_nettype none
`include "csrd_defines.svh"

module csrd_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] fetch_byte_i,
  input wire logic [7:0] wreg_base_i,
  input wire logic [7:0] mem_rdata_i,
  output logic fetch_ready_o,
  output logic fetch_flush_o,
  output logic [11:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [11:0] sp_o,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o,
  output logic busy_o,
  output logic illegal_op_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Register field to 12-bit address; escaped fields land in the working bank
  function automatic logic [11:0] reg_addr(input logic [7:0] f, input logic [7:0] base);
    reg_addr = (f[7:4] == `CSRD_ESC_NIBBLE) ? {base, f[3:0]} : {4'h0, f};
  endfunction

  // Bytes from opcode onward; zero means not decoded here
  function automatic logic [1:0] op_len(input logic [7:0] op);
    case (op)
      `CSRD_OPC_ADD_REGS, `CSRD_OPC_POP_EXT, `CSRD_OPC_PUSH_EXT: op_len = 2'h3;
      `CSRD_OPC_PUSH_R, `CSRD_OPC_PUSH_IND,
      `CSRD_OPC_ROTL_CARRY_REG, `CSRD_OPC_ROTL_CARRY_IND,
      `CSRD_OPC_ROTR_CARRY_REG, `CSRD_OPC_ROTR_CARRY_IND,
      `CSRD_OPC_ROTL_REG, `CSRD_OPC_ROTL_IND,
      `CSRD_OPC_ROTR_REG, `CSRD_OPC_ROTR_IND: op_len = 2'h2;
      `CSRD_OPC_RETURN: op_len = 2'h1;
      default: op_len = 2'h0;
    endcase
  endfunction

  function automatic logic [2:0] exec_len(input logic [7:0] op);
    case (op)
      `CSRD_OPC_PUSH_IND, `CSRD_OPC_ROTL_CARRY_IND, `CSRD_OPC_ROTR_CARRY_IND,
      `CSRD_OPC_ROTL_IND, `CSRD_OPC_ROTR_IND: exec_len = `CSRD_EXEC_THREE;
      `CSRD_OPC_RETURN: exec_len = `CSRD_EXEC_FOUR;
      `CSRD_OPC_ADD_REGS: exec_len = `CSRD_EXEC_ADD;
      default: exec_len = `CSRD_EXEC_TWO;
    endcase
  endfunction

  // Rotate by opcode family; returns {carry, result}
  function automatic logic [8:0] rotate(input logic [7:0] op, input logic [7:0] d,
                                        input logic c);
    case (op[7:4])
      4'h1: rotate = {d[7], d[6:0], c};
      4'hc: rotate = {d[0], c, d[7:1]};
      4'h9: rotate = {d[7], d[6:0], d[7]};
      default: rotate = {d[0], d[0], d[7:1]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csrd_pkg::csrd_state_t state_ff, nxt_state;
  logic [1:0] idx_ff, nxt_idx;
  logic pre_ff, nxt_pre;
  logic [7:0] opc_ff, nxt_opc;
  logic [7:0] b1_ff, nxt_b1;
  logic [7:0] b2_ff, nxt_b2;
  logic [7:0] tmp_ff, nxt_tmp;
  logic [2:0] step_ff, nxt_step;
  logic [11:0] sp_ff, nxt_sp;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] flags_ff, nxt_flags;
  logic [11:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic we_ff, nxt_we;
  logic re_ff, nxt_re;
  logic ready_ff, nxt_ready;
  logic flush_ff, nxt_flush;
  logic illegal_ff, nxt_illegal;
  logic [7:0] cur_op;
  logic [8:0] rot;
  logic [8:0] sum;
  logic [4:0] half;
  logic [11:0] sp_dec;

  assign cur_op = (idx_ff == 2'h0) ? fetch_byte_i : opc_ff;
  assign rot = rotate(opc_ff, mem_rdata_i, flags_ff[`CSRD_FLAG_C]);
  assign sum = {1'b0, tmp_ff} + {1'b0, mem_rdata_i};
  assign half = {1'b0, tmp_ff[3:0]} + {1'b0, mem_rdata_i[3:0]};
  assign sp_dec = sp_ff - 12'h001;

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  // Memory reads are combinational: data for addr_ff is on mem_rdata_i the same cycle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_pre = pre_ff;
    nxt_opc = opc_ff;
    nxt_b1 = b1_ff;
    nxt_b2 = b2_ff;
    nxt_tmp = tmp_ff;
    nxt_step = step_ff;
    nxt_sp = sp_ff;
    nxt_pc = pc_ff;
    nxt_flags = flags_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_re = 1'b0;
    nxt_ready = ready_ff;
    nxt_flush = 1'b0;
    nxt_illegal = 1'b0;
    case (state_ff)
      csrd_pkg::CSRD_FETCH:
      begin
        if (fetch_valid_i && ready_ff)
        begin
          nxt_pc = pc_ff + 16'h0001;
          if (idx_ff == 2'h0 && !pre_ff && fetch_byte_i == `CSRD_OPC_PREFIX)
            nxt_pre = 1'b1;
          else if (idx_ff == 2'h0 && (op_len(fetch_byte_i) == 2'h0 ||
                   (pre_ff && fetch_byte_i != `CSRD_OPC_PUSH_R)))
          begin
            nxt_pre = 1'b0;
            nxt_illegal = 1'b1;
          end
          else
          begin
            // Source byte is taken first, destination byte last
            if (idx_ff == 2'h0)
              nxt_opc = fetch_byte_i;
            if (idx_ff == 2'h1)
              nxt_b1 = fetch_byte_i;
            if (idx_ff == 2'h2)
              nxt_b2 = fetch_byte_i;
            nxt_idx = idx_ff + 2'h1;
            if (idx_ff + 2'h1 == op_len(cur_op))
            begin
              nxt_state = csrd_pkg::CSRD_EXEC;
              nxt_ready = 1'b0;
              nxt_step = 3'h0;
              nxt_idx = 2'h0;
              // Launch the first operand read
              case (cur_op)
                `CSRD_OPC_ADD_REGS:
                begin
                  nxt_re = 1'b1;
                  nxt_addr = reg_addr(b1_ff, wreg_base_i);
                end
                `CSRD_OPC_PUSH_EXT:
                begin
                  nxt_re = 1'b1;
                  nxt_addr = {b1_ff[3:0], fetch_byte_i};
                end
                `CSRD_OPC_POP_EXT, `CSRD_OPC_RETURN:
                begin
                  nxt_re = 1'b1;
                  nxt_addr = sp_ff;
                end
                default:
                begin
                  nxt_re = !pre_ff;
                  nxt_addr = reg_addr(fetch_byte_i, wreg_base_i);
                end
              endcase
            end
          end
        end
      end
      csrd_pkg::CSRD_EXEC:
      begin
        nxt_step = step_ff + 3'h1;
        if (step_ff == exec_len(opc_ff) - 3'h1)
        begin
          nxt_state = csrd_pkg::CSRD_FETCH;
          nxt_ready = 1'b1;
          nxt_pre = 1'b0;
        end
        case (opc_ff)
          `CSRD_OPC_ADD_REGS:
          begin
            if (step_ff == 3'h0)
            begin
              nxt_tmp = mem_rdata_i;
              nxt_re = 1'b1;
              nxt_addr = reg_addr(b2_ff, wreg_base_i);
            end
            else if (step_ff == 3'h1)
            begin
              nxt_we = 1'b1;
              nxt_wdata = sum[7:0];
              nxt_flags[`CSRD_FLAG_C] = sum[8];
              nxt_flags[`CSRD_FLAG_Z] = (sum[7:0] == 8'h00);
              nxt_flags[`CSRD_FLAG_S] = sum[7];
              nxt_flags[`CSRD_FLAG_V] = (tmp_ff[7] == mem_rdata_i[7]) && (sum[7] != tmp_ff[7]);
              nxt_flags[`CSRD_FLAG_D] = 1'b0;
              nxt_flags[`CSRD_FLAG_H] = half[4];
            end
          end
          `CSRD_OPC_POP_EXT:
          begin
            if (step_ff == 3'h0)
            begin
              nxt_we = 1'b1;
              nxt_addr = {b1_ff[3:0], b2_ff};
              nxt_wdata = mem_rdata_i;
              nxt_sp = sp_ff + 12'h001;
            end
          end
          `CSRD_OPC_RETURN:
          begin
            if (step_ff == 3'h0)
            begin
              nxt_tmp = mem_rdata_i;
              nxt_re = 1'b1;
              nxt_addr = sp_ff + 12'h001;
            end
            else if (step_ff == 3'h1)
            begin
              nxt_pc = {tmp_ff, mem_rdata_i};
              nxt_sp = sp_ff + 12'h002;
              nxt_flush = 1'b1;
            end
          end
          `CSRD_OPC_PUSH_R, `CSRD_OPC_PUSH_EXT, `CSRD_OPC_PUSH_IND:
          begin
            // Indirect form spends one extra step chasing the pointer
            if (opc_ff == `CSRD_OPC_PUSH_IND && step_ff == 3'h0)
            begin
              nxt_re = 1'b1;
              nxt_addr = {4'h0, mem_rdata_i};
            end
            else if (step_ff == ((opc_ff == `CSRD_OPC_PUSH_IND) ? 3'h1 : 3'h0))
            begin
              nxt_sp = sp_dec;
              nxt_we = 1'b1;
              nxt_addr = sp_dec;
              nxt_wdata = pre_ff ? b1_ff : mem_rdata_i;
            end
          end
          default:
          begin
            // Rotates; odd opcodes are the indirect forms
            if (opc_ff[0] && step_ff == 3'h0)
            begin
              nxt_re = 1'b1;
              nxt_addr = {4'h0, mem_rdata_i};
            end
            else if (step_ff == {2'h0, opc_ff[0]})
            begin
              nxt_we = 1'b1;
              nxt_wdata = rot[7:0];
              nxt_flags[`CSRD_FLAG_C] = rot[8];
              nxt_flags[`CSRD_FLAG_Z] = (rot[7:0] == 8'h00);
              nxt_flags[`CSRD_FLAG_S] = rot[7];
              nxt_flags[`CSRD_FLAG_V] = rot[7] ^ mem_rdata_i[7];
            end
          end
        endcase
      end
      default:
      begin
        nxt_state = csrd_pkg::CSRD_FETCH;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= csrd_pkg::CSRD_FETCH;
      idx_ff <= 2'h0;
      pre_ff <= 1'b0;
      opc_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      tmp_ff <= 8'h00;
      step_ff <= 3'h0;
      ready_ff <= 1'b1;
      flush_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      pre_ff <= nxt_pre;
      opc_ff <= nxt_opc;
      b1_ff <= nxt_b1;
      b2_ff <= nxt_b2;
      tmp_ff <= nxt_tmp;
      step_ff <= nxt_step;
      ready_ff <= nxt_ready;
      flush_ff <= nxt_flush;
      illegal_ff <= nxt_illegal;
    end
  end

  // Architectural state: stack pointer, program counter, flags
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sp_ff <= `CSRD_SP_RESET;
      pc_ff <= `CSRD_PC_RESET;
      flags_ff <= `CSRD_FLAGS_RESET;
    end
    else
    begin
      sp_ff <= nxt_sp;
      pc_ff <= nxt_pc;
      flags_ff <= nxt_flags;
    end
  end

  // Memory port; registered so the register file sees clean strobes
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      addr_ff <= 12'h000;
      wdata_ff <= 8'h00;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
    end
    else
    begin
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
    end
  end

  assign fetch_ready_o = ready_ff;
  assign fetch_flush_o = flush_ff;
  assign mem_addr_o = addr_ff;
  assign mem_wdata_o = wdata_ff;
  assign mem_we_o = we_ff;
  assign mem_re_o = re_ff;
  assign sp_o = sp_ff;
  assign pc_o = pc_ff;
  assign flags_o = flags_ff;
  assign busy_o = state_ff[1];
  assign illegal_op_o = illegal_ff;

endmodule

`default_nettype wire

// [bench/csrd_core_properties.sv]
// Concurrent checks on the stack and rotate core ports
`timescale 1ns/100ps
`default_nettype none
module csrd_core_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic fetch_ready_o,
  input wire logic fetch_flush_o,
  input wire logic mem_we_o,
  input wire logic [11:0] sp_o,
  input wire logic [15:0] pc_o,
  input wire logic [7:0] flags_o,
  input wire logic busy_o
);
  // ----------------------------------------
  // Timing and side-effect checks
  // ----------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Every instruction executes for two to four cycles
  sequence s_exec_min;
    busy_o [*2];
  endsequence
  sequence s_back_ready;
    !busy_o && fetch_ready_o;
  endsequence
  chk_exec_span: assert property ($rose(busy_o) |-> s_exec_min ##[1:3] s_back_ready)
    else $error("execution length out of range");
  chk_pc_step: assert property (fetch_valid_i && fetch_ready_o |=> pc_o == $past(pc_o) + 16'h0001)
    else $error("program counter did not step on a taken byte");
  chk_sp_delta: assert property ($changed(sp_o) |-> sp_o == $past(sp_o) - 12'h001
    || sp_o == $past(sp_o) + 12'h001 || sp_o == $past(sp_o) + 12'h002)
    else $error("stack pointer moved by an illegal amount");
  chk_stack_flags: assert property ($changed(sp_o) |-> $stable(flags_o))
    else $error("stack operation altered the flags");
  chk_return_sp: assert property (fetch_flush_o |-> busy_o && sp_o == $past(sp_o) + 12'h002)
    else $error("return did not add two to the stack pointer");
  chk_return_tail: assert property (fetch_flush_o |-> ##1 (busy_o && !fetch_flush_o) ##1 fetch_ready_o)
    else $error("return tail timing wrong");
  chk_write_once: assert property (mem_we_o |-> busy_o ##1 !mem_we_o)
    else $error("memory write outside execution or repeated");
  chk_flags_busy: assert property ($changed(flags_o) |-> busy_o)
    else $error("flags changed outside execution");
endmodule
bind csrd_core csrd_core_properties u_props (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .fetch_valid_i(fetch_valid_i),
  .fetch_ready_o(fetch_ready_o),
  .fetch_flush_o(fetch_flush_o),
  .mem_we_o(mem_we_o),
  .sp_o(sp_o),
  .pc_o(pc_o),
  .flags_o(flags_o),
  .busy_o(busy_o)
);
`default_nettype wire

// [bench/tb_cpu_stack_rotate_decode.sv]
// Self-checking bench for the stack and rotate core
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_stack_rotate_decode;
  logic core_clk_i, rst_i, fetch_valid_i, fetch_ready_o, fetch_flush_o;
  logic mem_we_o, mem_re_o, busy_o, illegal_op_o;
  logic [7:0] fetch_byte_i, wreg_base_i, mem_rdata_i, mem_wdata_o, flags_o, ef;
  logic [11:0] mem_addr_o, sp_o;
  logic [15:0] pc_o;
  logic [7:0] mem [0:4095];
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n_reads = 0;
  csrd_core dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .fetch_valid_i(fetch_valid_i),
    .fetch_byte_i(fetch_byte_i),
    .wreg_base_i(wreg_base_i),
    .mem_rdata_i(mem_rdata_i),
    .fetch_ready_o(fetch_ready_o),
    .fetch_flush_o(fetch_flush_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o),
    .sp_o(sp_o),
    .pc_o(pc_o),
    .flags_o(flags_o),
    .busy_o(busy_o),
    .illegal_op_o(illegal_op_o)
  );
  // ----------------------------------------
  // Clock, register file and watchdog
  // ----------------------------------------
  always #2 core_clk_i = ~core_clk_i;
  // Read is combinational, as the core expects from its register file
  assign mem_rdata_i = mem[mem_addr_o];
  always @(posedge core_clk_i)
    if (mem_we_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
  // Read strobes are counted mid-cycle, where the registered pulse has settled
  always @(negedge core_clk_i)
    if (mem_re_o === 1'b1) n_reads++;
  // A hung handshake ends the run as a failure
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // Bytes are offered at the falling edge once the core is ready; valid stays
  // up between bytes so it is never lowered and raised in one time step
  task automatic feed(input logic [7:0] b);
    while (fetch_ready_o !== 1'b1) @(negedge core_clk_i);
    fetch_valid_i = 1'b1;
    fetch_byte_i = b;
    @(negedge core_clk_i);
  endtask
  // Sends nb bytes, most significant first, then counts busy cycles
  task automatic run(input logic [23:0] code, input int nb, input int n);
    int k;
    k = 0;
    for (int i = 0; i < nb; i++) feed(code[23 - 8 * i -: 8]);
    fetch_valid_i = 1'b0;
    while (fetch_ready_o !== 1'b1 && k < 8)
    begin
      if (busy_o === 1'b1) k++;
      @(negedge core_clk_i);
    end
    chk("exec_cycles", 16'(n), 16'(k));
  endtask
  function automatic logic [8:0] rot(input logic [7:0] op, input logic [7:0] v, input logic c);
    case (op[7:4])
      4'h9: rot = {v[7], v[6:0], v[7]};
      4'h1: rot = {v[7], v[6:0], c};
      4'he: rot = {v[0], v[0], v[7:1]};
      default: rot = {v[0], c, v[7:1]};
    endcase
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_add();
    mem[12'h028] = 8'h01;
    mem[12'h043] = 8'h0f;
    run(24'h04e843, 3, 3);
    chk("add_dst", 16'h0010, mem[12'h043]);
    chk("add_src", 16'h0001, mem[12'h028]);
    chk("add_reads", 16'h0002, 16'(n_reads));
    ef = 8'h04;
    chk("add_flags", ef, flags_o);
  endtask
  // Register and indirect forms of every rotate, carry chained through
  task automatic test_rotates();
    logic [7:0] ops [8] = '{8'h90, 8'h10, 8'he0, 8'hc0, 8'h91, 8'h11, 8'he1, 8'hc1};
    logic [7:0] vals [8] = '{8'h81, 8'h40, 8'h01, 8'h02, 8'h80, 8'h7f, 8'h00, 8'hc3};
    logic [8:0] r;
    logic [11:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = ops[i][0] ? 12'h030 : 12'h010;
      mem[12'h011] = 8'h30;
      mem[a] = vals[i];
      r = rot(ops[i], vals[i], ef[7]);
      ef = {r[8], r[7:0] == 8'h00, r[7], r[7] ^ vals[i][7], ef[3:0]};
      run({ops[i], ops[i][0] ? 8'h11 : 8'h10, 8'h00}, 2, ops[i][0] ? 3 : 2);
      chk("rot_result", r[7:0], mem[a]);
      chk("rot_flags", ef, flags_o);
    end
  endtask
  task automatic test_stack();
    mem[12'h010] = 8'ha5;
    mem[12'h030] = 8'h3c;
    mem[12'h123] = 8'h77;
    run(24'h701000, 2, 2);
    chk("push_r", 16'h0a5, mem[12'hfff]);
    run(24'h711100, 2, 3);
    chk("push_ir", 16'h03c, mem[12'hffe]);
    run(24'h1f705a, 3, 2);
    chk("push_im", 16'h05a, mem[12'hffd]);
    run(24'hc80123, 3, 2);
    chk("push_ext", 16'h077, mem[12'hffc]);
    chk("sp_push", 16'h0ffc, sp_o);
    run(24'hd80456, 3, 2);
    chk("pop_ext", 16'h077, mem[12'h456]);
    chk("sp_pop", 16'h0ffd, sp_o);
    run(24'haf0000, 1, 4);
    chk("ret_pc", 16'h5a3c, pc_o);
    chk("ret_sp", 16'h0fff, sp_o);
    chk("stack_flags", ef, flags_o);
    chk("read_total", 16'h0015, 16'(n_reads));
  endtask
  // Unknown opcode and a prefix without its partner are both refused
  task automatic test_illegal();
    feed(8'hff);
    chk("illegal_op", 16'h0001, illegal_op_o);
    feed(8'h1f);
    feed(8'h00);
    fetch_valid_i = 1'b0;
    chk("illegal_pfx", 16'h0001, illegal_op_o);
    chk("illegal_pc", 16'h5a3f, pc_o);
    chk("illegal_sp", 16'h0fff, sp_o);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    core_clk_i = 1'b0;
    rst_i = 1'b1;
    fetch_valid_i = 1'b0;
    fetch_byte_i = 8'h00;
    wreg_base_i = 8'h02;
    ef = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk("reset_sp", 16'h0000, sp_o);
    test_add();
    test_rotates();
    test_stack();
    test_illegal();
    print_verdict();
  end
endmodule
`default_nettype wire
